/* ssic_pkg.sv */
// Package of constants and types for the synchronous SRAM input control block.
package ssic_pkg;

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W_DEF = 20;
  localparam int LANES_DEF = 4;
  localparam int BURST_W = 2;
  localparam int LATENCY = 2;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [1:0] RST_PIPE = 2'h0;
  localparam logic [1:0] RST_BURST = 2'h0;

  // ----------------------------------------------------------------
  // Access kinds
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SSIC_IDLE = 2'b00,
    SSIC_READ = 2'b01,
    SSIC_WRITE = 2'b10
  } ssic_op_e;

endpackage : ssic_pkg

/* ssic_burst_ctr.sv */
// Two-bit burst counter with linear or interleaved order.
`timescale 1ns/10ps
module ssic_burst_ctr
  import ssic_pkg::*;
(
  input wire logic clock, // Clock.
  input wire logic rstn, // Async reset, low.
  input wire logic enable, // Effective edge.
  input wire logic load, // Load start bits.
  input wire logic step, // Advance burst.
  input wire logic interleaved, // Order select.
  input wire logic [BURST_W-1:0] startBits, // Start bits.
  output logic [BURST_W-1:0] burstBits // Bits after this edge.
);

  logic [BURST_W-1:0] base_ff;
  logic [BURST_W-1:0] cnt_ff;
  logic [BURST_W-1:0] nxt_base;
  logic [BURST_W-1:0] nxt_cnt;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    nxt_base = base_ff;
    nxt_cnt = cnt_ff;
    if (enable && load)
    begin
      nxt_base = startBits;
      nxt_cnt = RST_BURST;
    end
    else if (enable && step)
    begin
      nxt_cnt = cnt_ff + 2'h1;
    end
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      base_ff <= RST_BURST;
      cnt_ff <= RST_BURST;
    end
    else
    begin
      base_ff <= nxt_base;
      cnt_ff <= nxt_cnt;
    end
  end

  // Interleaved order xors the count into the start, linear order adds it.
  // The output shows the address that this edge moves to, so an advance gets the next word.
  assign burstBits = interleaved ? (nxt_base ^ nxt_cnt) : (nxt_base + nxt_cnt);

  a_burst_hold: assert property (@(posedge clock) disable iff (!rstn)
    !enable |=> $stable(cnt_ff) && $stable(base_ff))
    else $error("burst counter moved on a suspended edge");
  a_burst_step: assert property (@(posedge clock) disable iff (!rstn)
    enable && step && !load |=> cnt_ff == $past(cnt_ff) + 2'h1)
    else $error("burst counter did not step");

endmodule : ssic_burst_ctr

/* ssic_input_ctrl.sv */
// Input control of a pipelined burst SRAM with no dead cycles.
// What this block does
// - Capture address on rising clock edge
// - Byte select gates only its lane
// - Write enable sampled only when enabled
// - Advance high steps burst counter
// - Advance low loads new address
// - Edges with clock gate high ignored
// - All inputs registered on one clock
// - Clock gate high holds state, clears read/write strobes
// - Select needs cs1 low, cs2 high, cs3 low
// - Data pins float on write, deselect
`timescale 1ns/10ps
module ssic_input_ctrl
  import ssic_pkg::*;
#(
  parameter int ADDR_W = ADDR_W_DEF, // Address width.
  parameter int LANES = LANES_DEF // Byte lanes.
)
(
  input wire logic clock, // Clock, 20 MHz.
  input wire logic rstn, // Async reset, low.
  input wire logic clock_gate_n, // Clock enable, low.
  input wire logic chip_select1_n, // Chip select 1, low.
  input wire logic chip_select2, // Chip select 2, high.
  input wire logic chip_select3_n, // Chip select 3, low.
  input wire logic advance_or_load, // High advance, low load.
  input wire logic write_en_n, // Write enable, low.
  input wire logic interleaved, // Burst order, static.
  input wire logic [ADDR_W-1:0] address, // Address incl. burst bits.
  input wire logic [LANES-1:0] byte_write_sel_n, // Byte selects, low.
  input wire logic [LANES*8-1:0] data_lane_in, // Data pins in.
  input wire logic [LANES-1:0] parity_lane_in, // Parity pins in.
  output logic [ADDR_W-1:0] arrayAddr, // Address of data slot.
  output logic [LANES-1:0] laneWrite, // Lane write strobes.
  output logic [LANES*8-1:0] arrayWdata, // Write data.
  output logic [LANES-1:0] arrayWpar, // Write parity.
  output logic arrayRead, // Read strobe.
  output logic dataDriveEn // Data pin drive allowed.
);

  initial
  begin
    if (ADDR_W < 3 || LANES < 1 || LANES > 8)
      $error("ssic_input_ctrl: unsupported width");
  end

  // ----------------------------------------------------------------
  // Input decode
  // ----------------------------------------------------------------
  logic enabled;
  logic selected;
  logic loadCycle;
  logic [BURST_W-1:0] burstBits;
  assign enabled = !clock_gate_n;
  assign selected = !chip_select1_n && chip_select2 && !chip_select3_n;
  assign loadCycle = !advance_or_load;

  // ----------------------------------------------------------------
  // Address and operation pipeline
  // ----------------------------------------------------------------
  ssic_op_e op_ff [LATENCY];
  ssic_op_e nxt_op [LATENCY];
  logic [ADDR_W-1:0] addr_ff [LATENCY];
  logic [ADDR_W-1:0] nxt_addr [LATENCY];
  logic [LANES-1:0] bsel_ff [LATENCY];
  logic [LANES-1:0] nxt_bsel [LATENCY];
  logic fresh_ff [LATENCY];
  logic nxt_fresh [LATENCY];
  logic [ADDR_W-BURST_W-1:0] upper_ff;
  logic [ADDR_W-BURST_W-1:0] nxt_upper;
  logic burstWrite_ff;
  logic nxt_burstWrite;
  logic active_ff;
  logic nxt_active;
  logic wasDesel_ff;
  logic nxt_wasDesel;

  ssic_burst_ctr u_burst (
    .clock(clock),
    .rstn(rstn),
    .enable(enabled),
    .load(loadCycle && selected),
    .step(advance_or_load && active_ff),
    .interleaved(interleaved),
    .startBits(address[BURST_W-1:0]),
    .burstBits(burstBits)
  );

  always_comb
  begin
    nxt_op = op_ff;
    nxt_addr = addr_ff;
    nxt_bsel = bsel_ff;
    nxt_fresh = fresh_ff;
    nxt_upper = upper_ff;
    nxt_burstWrite = burstWrite_ff;
    nxt_active = active_ff;
    nxt_wasDesel = wasDesel_ff;
    if (enabled)
    begin
      for (int i = 1; i < LATENCY; i++)
      begin
        nxt_op[i] = op_ff[i-1];
        nxt_addr[i] = addr_ff[i-1];
        nxt_bsel[i] = bsel_ff[i-1];
        nxt_fresh[i] = fresh_ff[i-1];
      end
      nxt_bsel[0] = byte_write_sel_n;
      // A load right after a deselected load is the first clock out of deselect.
      nxt_fresh[0] = loadCycle && wasDesel_ff;
      if (loadCycle)
      begin
        nxt_active = selected;
        nxt_wasDesel = !selected;
        if (selected)
        begin
          nxt_upper = address[ADDR_W-1:BURST_W];
          nxt_burstWrite = !write_en_n;
          nxt_op[0] = write_en_n ? SSIC_READ : SSIC_WRITE;
          nxt_addr[0] = address;
        end
        else
        begin
          nxt_op[0] = SSIC_IDLE;
          nxt_addr[0] = addr_ff[0];
        end
      end
      else if (active_ff)
      begin
        nxt_wasDesel = 1'b0;
        nxt_op[0] = burstWrite_ff ? SSIC_WRITE : SSIC_READ;
        nxt_addr[0] = {upper_ff, burstBits};
      end
      else
      begin
        nxt_op[0] = SSIC_IDLE;
      end
    end
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      for (int i = 0; i < LATENCY; i++)
      begin
        op_ff[i] <= SSIC_IDLE;
        addr_ff[i] <= '0;
        bsel_ff[i] <= '1;
        fresh_ff[i] <= 1'b0;
      end
      upper_ff <= '0;
      burstWrite_ff <= 1'b0;
      active_ff <= 1'b0;
      wasDesel_ff <= 1'b1;
    end
    else
    begin
      op_ff <= nxt_op;
      addr_ff <= nxt_addr;
      bsel_ff <= nxt_bsel;
      fresh_ff <= nxt_fresh;
      upper_ff <= nxt_upper;
      burstWrite_ff <= nxt_burstWrite;
      active_ff <= nxt_active;
      wasDesel_ff <= nxt_wasDesel;
    end
  end

  // ----------------------------------------------------------------
  // Data slot, two enabled edges after the address
  // ----------------------------------------------------------------
  logic [LANES*8-1:0] wdata_ff;
  logic [LANES*8-1:0] nxt_wdata;
  logic [LANES-1:0] wpar_ff;
  logic [LANES-1:0] nxt_wpar;
  logic [LANES-1:0] laneWr_ff;
  logic [LANES-1:0] nxt_laneWr;
  logic read_ff;
  logic nxt_read;
  logic drive_ff;
  logic nxt_drive;
  logic [ADDR_W-1:0] slotAddr_ff;
  logic [ADDR_W-1:0] nxt_slotAddr;
  ssic_op_e slotOp;
  assign slotOp = op_ff[LATENCY-1];

  always_comb
  begin
    nxt_wdata = wdata_ff;
    nxt_wpar = wpar_ff;
    nxt_slotAddr = slotAddr_ff;
    nxt_laneWr = '0;
    nxt_read = 1'b0;
    nxt_drive = drive_ff;
    if (enabled)
    begin
      nxt_wdata = data_lane_in;
      nxt_wpar = parity_lane_in;
      nxt_slotAddr = addr_ff[LATENCY-1];
      for (int l = 0; l < LANES; l++)
        nxt_laneWr[l] = (slotOp == SSIC_WRITE) && !bsel_ff[LATENCY-1][l];
      nxt_read = (slotOp == SSIC_READ);
      // Pins float during write data, deselect and the edge after it.
      nxt_drive = (slotOp == SSIC_READ) && !fresh_ff[LATENCY-1];
    end
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      wdata_ff <= '0;
      wpar_ff <= '0;
      slotAddr_ff <= '0;
      laneWr_ff <= '0;
      read_ff <= 1'b0;
      drive_ff <= 1'b0;
    end
    else
    begin
      wdata_ff <= nxt_wdata;
      wpar_ff <= nxt_wpar;
      slotAddr_ff <= nxt_slotAddr;
      laneWr_ff <= nxt_laneWr;
      read_ff <= nxt_read;
      drive_ff <= nxt_drive;
    end
  end

  assign arrayAddr = slotAddr_ff;
  assign arrayWdata = wdata_ff;
  assign arrayWpar = wpar_ff;
  assign laneWrite = laneWr_ff;
  assign arrayRead = read_ff;
  assign dataDriveEn = drive_ff;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_suspend_hold: assert property (@(posedge clock) disable iff (!rstn)
    clock_gate_n |=> $stable(addr_ff[0]) && $stable(active_ff))
    else $error("state changed while clock gated");
  a_no_strobe_gated: assert property (@(posedge clock) disable iff (!rstn)
    clock_gate_n |=> laneWrite == '0 && !arrayRead)
    else $error("strobe on ignored edge");
  a_write_latency: assert property (@(posedge clock) disable iff (!rstn)
    enabled && selected && loadCycle && !write_en_n && byte_write_sel_n[0] ##1 enabled
    ##1 enabled |=> !laneWrite[0])
    else $error("deselected lane written");
  a_read_latency: assert property (@(posedge clock) disable iff (!rstn)
    enabled && selected && loadCycle && write_en_n ##1 enabled ##1 enabled |=> arrayRead)
    else $error("read not two enabled cycles later");
  a_addr_capture: assert property (@(posedge clock) disable iff (!rstn)
    enabled && selected && loadCycle |=> addr_ff[0] == $past(address))
    else $error("address not captured");
  a_desel_idle: assert property (@(posedge clock) disable iff (!rstn)
    enabled && loadCycle && !selected |=> op_ff[0] == SSIC_IDLE)
    else $error("deselected cycle not idle");
  a_float_write: assert property (@(posedge clock) disable iff (!rstn)
    |laneWrite |-> !dataDriveEn)
    else $error("pins driven during write data");
  a_we_gated: assert property (@(posedge clock) disable iff (!rstn)
    clock_gate_n |=> $stable(burstWrite_ff))
    else $error("write enable sampled while gated");

  c_read: cover property (@(posedge clock) arrayRead);
  c_write: cover property (@(posedge clock) |laneWrite);
  c_burst: cover property (@(posedge clock) enabled && advance_or_load && active_ff);
  c_suspend: cover property (@(posedge clock) clock_gate_n && active_ff);

endmodule : ssic_input_ctrl

/* ssic_ctrl_model.sv */
// Memory controller model that drives the synchronous SRAM input pins at random.
`timescale 1ns/10ps
module ssic_ctrl_model
  import ssic_pkg::*;
(
  input wire logic clock, // Clock.
  input wire logic rstn, // Reset, low.
  input wire logic strict, // Load first after deselect.
  output logic clock_gate_n, // Clock enable, low.
  output logic chip_select1_n, // Select 1, low.
  output logic chip_select2, // Select 2, high.
  output logic chip_select3_n, // Select 3, low.
  output logic advance_or_load, // High advance.
  output logic write_en_n, // Write, low.
  output logic [ADDR_W_DEF-1:0] address, // Address.
  output logic [LANES_DEF-1:0] byte_write_sel_n, // Byte selects.
  output logic [LANES_DEF*8-1:0] data_lane_in, // Data.
  output logic [LANES_DEF-1:0] parity_lane_in // Parity.
);
  int seed = 32'hee378a89;
  logic [31:0] r;
  logic [31:0] r2;
  logic wasDesel = 1'b1;
  initial
  begin
    {clock_gate_n, chip_select1_n, chip_select2, chip_select3_n} = 4'h0;
    {advance_or_load, write_en_n, address, byte_write_sel_n} = '0;
    {data_lane_in, parity_lane_in} = '0;
  end
  // Data lines change every cycle, so an unused slot never repeats a value.
  always @(negedge clock)
  begin
    r = $random(seed);
    r2 = $random(seed);
    if (!rstn)
      wasDesel = 1'b1;
    else if (!clock_gate_n && !advance_or_load)
      wasDesel = !(!chip_select1_n && chip_select2 && !chip_select3_n);
    clock_gate_n <= (r[2:0] == 3'h0);
    chip_select1_n <= r[3] & r[4];
    chip_select2 <= !(r[5] & r[6]);
    chip_select3_n <= r[8] & r[9];
    advance_or_load <= r[11] & !(strict && wasDesel);
    write_en_n <= r[12];
    byte_write_sel_n <= r[16:13];
    parity_lane_in <= r[20:17];
    address <= r2[ADDR_W_DEF-1:0];
    data_lane_in <= $random(seed);
  end
endmodule : ssic_ctrl_model

/* sync_sram_input_control_tb_top.sv */
// Self-checking testbench of the synchronous SRAM input control block.
`timescale 1ns/10ps
module sync_sram_input_control_tb_top;
  import ssic_pkg::*;
  logic clock, rstn, interleaved, strict, run;
  logic clock_gate_n, chip_select1_n, chip_select2, chip_select3_n;
  logic advance_or_load, write_en_n;
  logic [19:0] address, arrayAddr, base, expAddr;
  logic [3:0] byte_write_sel_n, parity_lane_in, laneWrite, arrayWpar, expLane, expPar;
  logic [31:0] data_lane_in, arrayWdata, expData;
  logic arrayRead, dataDriveEn, expRd, expDrv, active, prevDesel, nd;
  logic [1:0] pk [2];
  logic [19:0] pa [2];
  logic [3:0] pb [2];
  logic pd [2];
  logic [1:0] nk, lastK, cnt;
  int error_cnt = 0;
  int checked = 0;

  ssic_input_ctrl i_dut (.clock(clock), .rstn(rstn), .clock_gate_n(clock_gate_n),
    .chip_select1_n(chip_select1_n), .chip_select2(chip_select2),
    .chip_select3_n(chip_select3_n), .advance_or_load(advance_or_load),
    .write_en_n(write_en_n), .interleaved(interleaved), .address(address),
    .byte_write_sel_n(byte_write_sel_n), .data_lane_in(data_lane_in),
    .parity_lane_in(parity_lane_in), .arrayAddr(arrayAddr), .laneWrite(laneWrite),
    .arrayWdata(arrayWdata), .arrayWpar(arrayWpar), .arrayRead(arrayRead),
    .dataDriveEn(dataDriveEn));

  ssic_ctrl_model i_ctrl (.clock(clock), .rstn(rstn), .strict(strict),
    .clock_gate_n(clock_gate_n), .chip_select1_n(chip_select1_n),
    .chip_select2(chip_select2), .chip_select3_n(chip_select3_n),
    .advance_or_load(advance_or_load), .write_en_n(write_en_n), .address(address),
    .byte_write_sel_n(byte_write_sel_n), .data_lane_in(data_lane_in),
    .parity_lane_in(parity_lane_in));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic finish_test;
    $display("checked %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : finish_test

  // ----------------------------------------------------------------
  // Reference pipeline: slot two enabled edges after capture.
  // ----------------------------------------------------------------
  always @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      pk = '{2'h0, 2'h0};
      active = 1'b0;
      prevDesel = 1'b1;
      {expLane, expRd, expDrv} = '0;
    end
    else if (!clock_gate_n)
    begin
      nk = 2'h0;
      nd = 1'b1;
      if (!advance_or_load)
      begin
        if (!chip_select1_n && chip_select2 && !chip_select3_n)
        begin
          nk = write_en_n ? 2'h1 : 2'h2;
          base = address;
          cnt = 2'h0;
          nd = !prevDesel;
        end
        prevDesel = (nk == 2'h0);
        active = (nk != 2'h0);
        lastK = nk;
      end
      else if (active)
      begin
        cnt = cnt + 2'h1;
        nk = lastK;
      end
      expLane = (pk[1] == 2'h2) ? ~pb[1] : 4'h0;
      expRd = (pk[1] == 2'h1);
      expDrv = expRd && pd[1];
      expAddr = pa[1];
      expData = data_lane_in;
      expPar = parity_lane_in;
      pk[1] = pk[0];
      pa[1] = pa[0];
      pb[1] = pb[0];
      pd[1] = pd[0];
      pk[0] = nk;
      pa[0] = {base[19:2], interleaved ? base[1:0] ^ cnt : base[1:0] + cnt};
      pb[0] = byte_write_sel_n;
      pd[0] = nd;
    end
    else
    begin
      expLane = 4'h0;
      expRd = 1'b0;
    end
  end

  always @(negedge clock)
  begin
    if (run)
    begin
      chk(32'(laneWrite), 32'(expLane));
      chk(32'(arrayRead), 32'(expRd));
      chk(32'(dataDriveEn), 32'(expDrv));
      if (expLane != 4'h0 || expRd)
        chk(32'(arrayAddr), 32'(expAddr));
      if (expLane != 4'h0)
        chk(arrayWdata, expData);
      if (expLane != 4'h0)
        chk(32'(arrayWpar & expLane), 32'(expPar & expLane));
    end
  end

  initial
  begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  initial
  begin
    {rstn, interleaved, strict, run} = 4'h0;
    for (int p = 0; p < 3; p++)
    begin
      @(negedge clock);
      run = 1'b0;
      @(negedge clock);
      rstn = 1'b0;
      interleaved = (p == 1);
      strict = (p != 2);
      repeat (3) @(negedge clock);
      rstn = 1'b1;
      run = 1'b1;
      repeat (400) @(negedge clock);
      $display("test %0d done, mismatches %0d", p, error_cnt);
    end
    finish_test();
  end
endmodule : sync_sram_input_control_tb_top
